// *** rtl/tws_params.svh ***
// Offsets, field positions, reset values and timing counts of the three-wire synthesiser.
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// Rates of the system clock and of the crystal reference, in hertz.
`define TWS_CLK_HZ        50000000
`define TWS_XTAL_HZ       4000000
// Crystal enables come from an accumulator stepping in units of 100 kHz.
`define TWS_ACC_UNIT      100000
`define TWS_ACC_STEP      (`TWS_XTAL_HZ / `TWS_ACC_UNIT)
`define TWS_ACC_WRAP      (`TWS_CLK_HZ / `TWS_ACC_UNIT)

// Reference divider ratios per mode.
`define TWS_REF_MODE0     15'h0280
`define TWS_REF_MODE1     15'h0400
`define TWS_REF_MODE23    15'h0200

// Serial word layout.
`define TWS_WORD_BITS     19
`define TWS_PORT_BITS     4
`define TWS_DIV_LSB       4

// Comparison periods with exactly one divider pulse needed to declare lock.
`define TWS_LOCK_PERIODS  3'h4

// Register byte offsets.
`define TWS_STATUS_OFS    8'h00
`define TWS_INT_STAT_OFS  8'h04
`define TWS_INT_MASK_OFS  8'h08
`define TWS_REF_OFS       8'h0C

// Status fields.
`define TWS_ST_LOCK_BIT   0
`define TWS_ST_MODE_LSB   1
`define TWS_ST_PORT_LSB   4
`define TWS_ST_DIV_LSB    8

// Interrupt bits and reset values.
`define TWS_EV_LOAD_BIT   0
`define TWS_EV_LOCK_BIT   1
`define TWS_EV_UNLOCK_BIT 2
`define TWS_INT_RST       3'h0
`define TWS_DIV_RST       15'h0000
`define TWS_PORT_RST      4'h0

`endif

// *** rtl/tws_pkg.sv ***
// Types shared by the three-wire synthesiser control files.
package tws_pkg;

  typedef logic [14:0] tws_div_t;
  typedef logic [2:0]  tws_ev_t;

  typedef enum logic [1:0]
  {
    TWS_MODE0 = 2'h0,
    TWS_MODE1 = 2'h1,
    TWS_MODE2 = 2'h2,
    TWS_MODE3 = 2'h3
  } tws_mode_e;

endpackage : tws_pkg

// *** rtl/tws_sync.sv ***
// Two-flop synchroniser for pins that come from outside the clock domain.
module tws_sync
  import tws_pkg::*;
#(
  parameter int W = 6
)
(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : tws_sync

// *** rtl/tws_divider.sv ***
// Counter that emits one pulse for every ratio input ticks.
module tws_divider
  import tws_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     arst_n,
  input  wire logic     tick,
  input  wire tws_div_t ratio,
  output logic          pulse
);

  tws_div_t cnt_reg;
  logic     wrap;

  // A ratio of zero or one divides by one.
  assign wrap = (ratio <= 15'h0001) || (cnt_reg >= ratio - 15'h0001);

  // Count ticks and pulse on the last one of each cycle.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= '0;
      pulse   <= 1'b0;
    end
    else
    begin
      pulse <= tick && wrap;
      if (tick)
      begin
        cnt_reg <= wrap ? 15'h0000 : cnt_reg + 15'h0001;
      end
    end
  end

endmodule : tws_divider

// *** rtl/tws_top.sv ***
// Three-wire bus controlled synthesiser control logic with an APB status slave.
`include "tws_params.svh"

// ****************************************************************************
// Function
// ****************************************************************************
//
// Function
// - Divisor and ports are loaded only from the data, clock, enable wires.
// - One serial word carries both the divisor and the four port bits.
// - Data bits shift in only while enable is high.
// - Serial clock edges are ignored while enable is low.
// - Holding buffers take the shift register only on enable falling.
// - Divisor is 14 bits in mode 3, 15 bits in modes 0 to 2.
// - Crystal divided by 512 in modes 2 and 3, 1024 in 1, 640 in 0.
// - Divisor sets divider ratio; its output is phase-compared to comparison rate.
// - A 4 MHz crystal gives steps of 62.5, 100 and 125 kHz.
// - Lock pin floats when locked and pulls low otherwise.
// - Four open-collector outputs follow the four bits after the divisor.
module tws_top
  import tws_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        bus_data,
  input  wire logic        bus_clk,
  input  wire logic        bus_en,
  input  wire logic [1:0]  mode_sel,
  input  wire logic        rf_in,
  output logic             lock_o,
  output logic             lock_oe,
  output logic      [3:0]  open_collector_outputs_o,
  output logic      [3:0]  open_collector_outputs_oe,
  output logic             pump_up,
  output logic             pump_dn
);

  // **************************************************************************
  // Pin synchronisation and edge detection
  // **************************************************************************

  logic [5:0] pins_s;
  logic       data_s;
  logic       sclk_s;
  logic       en_s;
  logic       rf_s;
  tws_mode_e  mode_s;
  logic       sclk_d_reg;
  logic       en_d_reg;
  logic       rf_d_reg;
  logic       sclk_rise;
  logic       en_fall;
  logic       rf_rise;

  tws_sync #(.W(6)) u_sync
  (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in ({mode_sel, rf_in, bus_en, bus_clk, bus_data}),
    .sync_out (pins_s)
  );

  assign data_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign en_s   = pins_s[2];
  assign rf_s   = pins_s[3];
  assign mode_s = tws_mode_e'(pins_s[5:4]);

  // Delayed copies of synchronised pins give single-cycle edge strobes.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_d_reg <= 1'b0;
      en_d_reg   <= 1'b0;
      rf_d_reg   <= 1'b0;
    end
    else
    begin
      sclk_d_reg <= sclk_s;
      en_d_reg   <= en_s;
      rf_d_reg   <= rf_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_d_reg && en_s;
  assign en_fall   = en_d_reg && !en_s;
  assign rf_rise   = rf_s && !rf_d_reg;

  // **************************************************************************
  // Serial shift register and holding buffers
  // **************************************************************************

  logic [`TWS_WORD_BITS-1:0] shift_reg;
  tws_div_t                  divisor_reg;
  logic [3:0]                ports_reg;
  logic                      load_ev;

  // Bits enter at the bottom, so the divisor arrives first and MSB first.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_reg <= '0;
    end
    else if (sclk_rise)
    begin
      shift_reg <= {shift_reg[`TWS_WORD_BITS-2:0], data_s};
    end
  end

  // Holding buffers change only on the falling enable edge.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      divisor_reg <= `TWS_DIV_RST;
      ports_reg   <= `TWS_PORT_RST;
      load_ev     <= 1'b0;
    end
    else
    begin
      load_ev <= en_fall;
      if (en_fall)
      begin
        ports_reg <= shift_reg[`TWS_PORT_BITS-1:0];
        if (mode_s == TWS_MODE3)
        begin
          divisor_reg <= {1'b0, shift_reg[17:`TWS_DIV_LSB]};
        end
        else
        begin
          divisor_reg <= shift_reg[18:`TWS_DIV_LSB];
        end
      end
    end
  end

  // Port bits sink current while set; the pin level is always low.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      open_collector_outputs_o  <= 4'h0;
      open_collector_outputs_oe <= 4'h0;
    end
    else
    begin
      open_collector_outputs_o  <= 4'h0;
      open_collector_outputs_oe <= ports_reg;
    end
  end

  // **************************************************************************
  // Crystal reference and comparison frequency
  // **************************************************************************

  logic [9:0] acc_reg;
  logic       xtal_tick;
  tws_div_t   ref_ratio;
  logic       comp_tick;
  logic       divider_output_freq;

  // Fractional accumulator turns the system clock into 4 MHz enables.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_reg   <= 10'h000;
      xtal_tick <= 1'b0;
    end
    else if (acc_reg + 10'(`TWS_ACC_STEP) >= 10'(`TWS_ACC_WRAP))
    begin
      acc_reg   <= acc_reg + 10'(`TWS_ACC_STEP) - 10'(`TWS_ACC_WRAP);
      xtal_tick <= 1'b1;
    end
    else
    begin
      acc_reg   <= acc_reg + 10'(`TWS_ACC_STEP);
      xtal_tick <= 1'b0;
    end
  end

  // Reference ratio follows the mode select pin.
  always_comb
  begin
    case (mode_s)
      TWS_MODE0: ref_ratio = `TWS_REF_MODE0;
      TWS_MODE1: ref_ratio = `TWS_REF_MODE1;
      default:   ref_ratio = `TWS_REF_MODE23;
    endcase
  end

  tws_divider u_ref_div
  (
    .clk    (clk),
    .arst_n (arst_n),
    .tick   (xtal_tick),
    .ratio  (ref_ratio),
    .pulse  (comp_tick)
  );

  // The loaded divisor divides the prescaled oscillator input.
  tws_divider u_prog_div
  (
    .clk    (clk),
    .arst_n (arst_n),
    .tick   (rf_rise),
    .ratio  (divisor_reg),
    .pulse  (divider_output_freq)
  );

  // **************************************************************************
  // Phase comparator and lock detector
  // **************************************************************************

  logic [1:0] fpd_cnt_reg;
  logic [2:0] good_cnt_reg;
  logic       locked_reg;
  logic       lock_ev;
  logic       unlock_ev;

  // Classic detector: each input sets its flag, both set clear together.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pump_up <= 1'b0;
      pump_dn <= 1'b0;
    end
    else if ((pump_up || comp_tick) && (pump_dn || divider_output_freq))
    begin
      pump_up <= 1'b0;
      pump_dn <= 1'b0;
    end
    else
    begin
      pump_up <= pump_up || comp_tick;
      pump_dn <= pump_dn || divider_output_freq;
    end
  end

  // Lock needs several comparison periods each holding one divider pulse.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fpd_cnt_reg  <= 2'h0;
      good_cnt_reg <= 3'h0;
      locked_reg   <= 1'b0;
      lock_ev      <= 1'b0;
      unlock_ev    <= 1'b0;
    end
    else if (comp_tick)
    begin
      fpd_cnt_reg <= {1'b0, divider_output_freq};
      if (fpd_cnt_reg == 2'h1)
      begin
        good_cnt_reg <= (good_cnt_reg == `TWS_LOCK_PERIODS) ? good_cnt_reg
                                                             : good_cnt_reg + 3'h1;
        locked_reg   <= (good_cnt_reg + 3'h1 >= `TWS_LOCK_PERIODS);
        lock_ev      <= !locked_reg && (good_cnt_reg + 3'h1 >= `TWS_LOCK_PERIODS);
        unlock_ev    <= 1'b0;
      end
      else
      begin
        good_cnt_reg <= 3'h0;
        locked_reg   <= 1'b0;
        lock_ev      <= 1'b0;
        unlock_ev    <= locked_reg;
      end
    end
    else
    begin
      lock_ev   <= 1'b0;
      unlock_ev <= 1'b0;
      if (divider_output_freq && fpd_cnt_reg != 2'h3)
      begin
        fpd_cnt_reg <= fpd_cnt_reg + 2'h1;
      end
    end
  end

  // Lock pin floats while locked and sinks otherwise.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lock_o  <= 1'b0;
      lock_oe <= 1'b1;
    end
    else
    begin
      lock_o  <= 1'b0;
      lock_oe <= !locked_reg;
    end
  end

  // **************************************************************************
  // APB slave and interrupts
  // **************************************************************************

  tws_ev_t int_stat_reg;
  tws_ev_t int_mask_reg;
  tws_ev_t int_clr;
  logic    wr_en;
  logic    setup;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready;
  assign int_clr = (wr_en && paddr == `TWS_INT_STAT_OFS) ? pwdata[2:0] : 3'h0;

  // Status bits are sticky; a new event wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      int_stat_reg <= `TWS_INT_RST;
    end
    else
    begin
      int_stat_reg <= (int_stat_reg & ~int_clr) | {unlock_ev, lock_ev, load_ev};
    end
  end

  // Mask register and level interrupt output.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      int_mask_reg <= `TWS_INT_RST;
      irq          <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == `TWS_INT_MASK_OFS)
      begin
        int_mask_reg <= pwdata[2:0];
      end
      irq <= |(int_stat_reg & int_mask_reg);
    end
  end

  // Answer is prepared in the setup cycle and shown in the access cycle.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (setup)
      begin
        case (paddr)
          `TWS_STATUS_OFS:
          begin
            prdata[`TWS_ST_LOCK_BIT]                  <= locked_reg;
            prdata[`TWS_ST_MODE_LSB +: 2]             <= mode_s;
            prdata[`TWS_ST_PORT_LSB +: 4]             <= ports_reg;
            prdata[`TWS_ST_DIV_LSB +: 15]             <= divisor_reg;
          end
          `TWS_INT_STAT_OFS: prdata[2:0]  <= int_stat_reg;
          `TWS_INT_MASK_OFS: prdata[2:0]  <= int_mask_reg;
          `TWS_REF_OFS:      prdata[14:0] <= ref_ratio;
          default:           pslverr      <= 1'b1;
        endcase
      end
    end
  end

  // **************************************************************************
  // Assertions
  // **************************************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic [3:0] xt_gap_reg;

  // Helper counter of cycles since the last crystal enable.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      xt_gap_reg <= 4'h0;
    end
    else
    begin
      xt_gap_reg <= xtal_tick ? 4'h1 : ((xt_gap_reg == 4'hF) ? xt_gap_reg : xt_gap_reg + 4'h1);
    end
  end

  AST_NO_SHIFT_EN_LOW: assert property (!en_s |=> $stable(shift_reg))
    else $error("Shift register moved while enable was low.");

  AST_SHIFT_MSB_FIRST: assert property (
    sclk_rise |=> shift_reg == {$past(shift_reg[`TWS_WORD_BITS-2:0]), $past(data_s)})
    else $error("Serial bit not shifted in at the bottom.");

  AST_LOAD_ONLY_ON_FALL: assert property (
    ($changed(divisor_reg) || $changed(ports_reg)) |-> $past(en_fall))
    else $error("Holding buffers changed without an enable fall.");

  AST_MODE3_LENGTH: assert property (
    (en_fall && mode_s == TWS_MODE3) |=> divisor_reg == {1'b0, $past(shift_reg[17:4])})
    else $error("Mode 3 divisor is not the 14-bit field.");

  AST_PORTS_FOLLOW: assert property (
    en_fall |-> ##2 open_collector_outputs_oe == $past(shift_reg[3:0], 2))
    else $error("Port outputs do not follow the loaded port bits.");

  AST_REF_RATIO_MODE0: assert property (
    (mode_s == TWS_MODE0) |-> ref_ratio == 15'h0280)
    else $error("Mode 0 reference ratio is not 640.");

  AST_XTAL_SPACING: assert property (
    xtal_tick |-> (xt_gap_reg >= 4'hC) && (xt_gap_reg <= 4'hD))
    else $error("Crystal enable spacing is not 12 or 13 cycles.");

  AST_PFD_CLEARS: assert property (
    (pump_up && divider_output_freq) |=> !pump_up && !pump_dn)
    else $error("Pump up not cleared by a divider pulse.");

  AST_LOCK_FLOATS: assert property (
    $rose(locked_reg) |=> $fell(lock_oe))
    else $error("Lock pin still driven after lock.");

  AST_LOAD_FROM_WIRES: assert property (
    $changed(divisor_reg) |-> $past(en_d_reg) && !$past(en_s))
    else $error("Divisor changed without a serial load.");

endmodule : tws_top

// *** bench/tws_host_model.sv ***
// Behavioural host that drives the three-wire serial bus of the synthesiser.
module tws_host_model
(
  output logic bus_data,
  output logic bus_clk,
  output logic bus_en
);
  timeunit 1ns;
  timeprecision 1ns;

  // The link clock rests low and enable rests low between frames.
  initial
  begin
    bus_data = 1'b0;
    bus_clk  = 1'b0;
    bus_en   = 1'b0;
  end

  // Raises enable and shifts n bits, most significant first; enable stays high.
  task automatic frame(input logic [18:0] w, input int n);
    #5; // Keeps pin changes off the sampling clock edge.
    bus_en = 1'b1;
    #100;
    for (int i = n - 1; i >= 0; i--)
    begin
      bus_data = w[i];
      #80;
      bus_clk = 1'b1;
      #80;
      bus_clk = 1'b0;
    end
  endtask : frame

  // Drops enable, then lets the data line wander so stale bits never look valid.
  task automatic close();
    #5; // Keeps pin changes off the sampling clock edge.
    #100;
    bus_en = 1'b0;
    #80;
    bus_data = ~bus_data;
  endtask : close

  // Clocks the bus with enable low, which the device must ignore.
  task automatic noise(input int n);
    #5; // Keeps pin changes off the sampling clock edge.
    for (int i = 0; i < n; i++)
    begin
      bus_data = ~bus_data;
      #80;
      bus_clk = 1'b1;
      #80;
      bus_clk = 1'b0;
    end
  endtask : noise
endmodule : tws_host_model

// *** bench/tws_top_tb.sv ***
// Self-checking testbench of the three-wire synthesiser control block.
module tws_top_tb
  import tws_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        bus_data, bus_clk, bus_en, rf_in, lock_o, lock_oe, pump_up, pump_dn, rf_on, err;
  logic [1:0]  mode_sel;
  logic [3:0]  oc_o, oc_oe;
  int          num_errors, checks, rf_cnt;

  tws_host_model host (.bus_data(bus_data), .bus_clk(bus_clk), .bus_en(bus_en));

  tws_top uut (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .bus_data(bus_data), .bus_clk(bus_clk), .bus_en(bus_en), .mode_sel(mode_sel),
    .rf_in(rf_in), .lock_o(lock_o), .lock_oe(lock_oe), .open_collector_outputs_o(oc_o),
    .open_collector_outputs_oe(oc_oe), .pump_up(pump_up), .pump_dn(pump_dn));

  always #10 clk = ~clk;

  // Oscillator input with an 8 us period while enabled.
  always @(posedge clk)
  begin
    rf_cnt <= (rf_cnt == 199) ? 0 : rf_cnt + 1;
    if (rf_cnt == 199)
      rf_in <= rf_on & ~rf_in;
  end

  // ***************************************************************
  // Helpers
  // ***************************************************************

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; waits for pready, and only the watchdog ends a hang.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reads a register and compares data and error flag.
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
    chk("pslverr", 32'h0000_0000, {31'h0, err});
  endtask : rchk

  // Expected status word.
  function automatic logic [31:0] st(logic lk, logic [1:0] m, logic [3:0] p, logic [14:0] d);
    return {9'h000, d, p, 1'b0, m, lk};
  endfunction : st

  // Waits a bounded time for the lock enable to reach a level.
  task automatic wait_oe(input logic v, input int lim);
    for (int n = 0; n < lim && lock_oe !== v; n++)
      @(posedge clk);
  endtask : wait_oe

  // ***************************************************************
  // Scenarios
  // ***************************************************************

  // Reset values, reference ratio of every mode, read-only and unmapped places.
  task automatic t_regs();
    logic [14:0] ratio [4] = '{15'h0280, 15'h0400, 15'h0200, 15'h0200};
    rchk("status", 8'h00, st(1'b0, 2'h2, 4'h0, 15'h0000));
    rchk("int_stat", 8'h04, 32'h0000_0000);
    rchk("int_mask", 8'h08, 32'h0000_0000);
    chk("lock_oe", 32'h0000_0001, {31'h0, lock_oe});
    chk("oc_oe", 32'h0000_0000, {28'h0, oc_oe});
    for (int m = 0; m < 4; m++)
    begin
      mode_sel <= m[1:0];
      repeat (4) @(posedge clk);
      apb(1'b1, 8'h0C, 32'h0000_7fff);
      rchk("ref", 8'h0C, {17'h0, ratio[m]});
    end
    mode_sel <= 2'h2;
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    $display("test regs done");
  endtask : t_regs

  // Full load: old settings hold until enable falls, then divisor and ports update.
  task automatic t_load();
    host.frame({15'h4d2b, 4'h5}, 19);
    repeat (10) @(posedge clk);
    rchk("status held", 8'h00, st(1'b0, 2'h2, 4'h0, 15'h0000));
    chk("oc_oe held", 32'h0000_0000, {28'h0, oc_oe});
    host.close();
    repeat (8) @(posedge clk);
    rchk("status loaded", 8'h00, st(1'b0, 2'h2, 4'h5, 15'h4d2b));
    chk("oc_oe", 32'h0000_0005, {28'h0, oc_oe});
    chk("oc_o", 32'h0000_0000, {28'h0, oc_o});
    rchk("int_stat load", 8'h04, 32'h0000_0001);
    $display("test load done");
  endtask : t_load

  // Clock edges with enable low must leave the shift register untouched.
  task automatic t_gate();
    host.noise(6);
    host.frame(19'h0_0000, 0);
    host.close();
    repeat (8) @(posedge clk);
    rchk("status gated", 8'h00, st(1'b0, 2'h2, 4'h5, 15'h4d2b));
    $display("test gate done");
  endtask : t_gate

  // Mode 3 takes an 18 bit word; the older bit left over must be dropped.
  task automatic t_mode3();
    mode_sel <= 2'h3;
    repeat (4) @(posedge clk);
    host.frame({1'b0, 14'h1357, 4'h3}, 18);
    host.close();
    repeat (8) @(posedge clk);
    rchk("status mode3", 8'h00, st(1'b0, 2'h3, 4'h3, 15'h1357));
    chk("oc_oe mode3", 32'h0000_0003, {28'h0, oc_oe});
    mode_sel <= 2'h2;
    repeat (4) @(posedge clk);
    $display("test mode3 done");
  endtask : t_mode3

  // Interrupt masked, unmasked, then cleared by writing one.
  task automatic t_irq();
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    apb(1'b1, 8'h08, 32'hffff_ffff);
    rchk("int_mask", 8'h08, 32'h0000_0007);
    repeat (2) @(posedge clk);
    chk("irq on", 32'h0000_0001, {31'h0, irq});
    apb(1'b1, 8'h04, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    rchk("int_stat clr", 8'h04, 32'h0000_0000);
    apb(1'b1, 8'h08, 32'h0000_0000);
    $display("test irq done");
  endtask : t_irq

  // Divisor 16 against a 125 kHz input in mode 2 locks; removing the input unlocks.
  task automatic t_lock();
    host.frame({15'h0010, 4'h0}, 19);
    host.close();
    repeat (8) @(posedge clk);
    apb(1'b1, 8'h04, 32'h0000_0007);
    rf_on <= 1'b1;
    wait_oe(1'b0, 50000);
    chk("lock_oe locked", 32'h0000_0000, {31'h0, lock_oe});
    chk("lock_o", 32'h0000_0000, {31'h0, lock_o});
    rchk("status locked", 8'h00, st(1'b1, 2'h2, 4'h0, 15'h0010));
    rf_on <= 1'b0;
    wait_oe(1'b1, 20000);
    chk("lock_oe lost", 32'h0000_0001, {31'h0, lock_oe});
    chk("pump_up no rf", 32'h0000_0001, {31'h0, pump_up});
    chk("pump_dn no rf", 32'h0000_0000, {31'h0, pump_dn});
    rchk("int_stat lock", 8'h04, 32'h0000_0006);
    $display("test lock done");
  endtask : t_lock

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // Watchdog sized well above the lock and unlock waits.
  initial
  begin
    #1_900_000;
    num_errors++;
    close_out();
  end

  // Main sequence.
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    mode_sel = 2'h2;
    rf_in = 1'b0;
    rf_on = 1'b0;
    rf_cnt = 0;
    num_errors = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_load();
    t_gate();
    t_mode3();
    t_irq();
    t_lock();
    close_out();
  end
endmodule : tws_top_tb
